/* i2cm_ctrl.sv */
// Operation
// - An acknowledge sequence drives ack_value onto data: one is NACK, zero ACK.
// - ack_sequence_request runs the acknowledge bit and clears itself afterwards.
// - master_receive_request receives one byte and clears after its eighth bit.
// - stop_request generates a Stop and clears when it is done.
// - restart_request generates a Repeated Start and clears when it is done.
// - start_request generates a Start and clears when it is done.
// - ack_result takes the acknowledge sampled while the clock is high in the acknowledge slot of each master send.
// - master_tx_active spans eight data bits plus acknowledge of a master send.
// - collision_flag is set on a master collision and held until software clears.
// - general_call_seen sets on general call match, clears on Stop.
// - ten_bit_matched sets on second matching address byte, clears on Stop.
// - Writing tx_holding_reg while busy is dropped and sets tx_write_collision.
// - A received byte meeting a full rx_holding_reg sets rx_overflow.
// - Data-or-address flag clears on address match, sets after data bytes.
// - Start and Stop detection update the start-seen and stop-seen flags.
// - Direction flag follows the read/write bit of each matched address.
// - rx_full_flag sets on a new received byte, clears on register read.
// - tx_full_flag sets on software write, clears when that byte is sent.
// - A set addr_mask_bits bit makes that address bit a don't-care.
// - Unimplemented status and mask bits read as zero.
// - Reserved addresses never match, except the 10-bit header in 10-bit mode; general call needs general_call_enable.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module i2cm_ctrl (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire i2cm_pkg::i2cm_bus_s bus,
   output logic [15:0]              rd_data,
   input  wire logic                scl_i,
   output logic                     scl_o,
   output logic                     scl_oe,
   input  wire logic                sda_i,
   output logic                     sda_o,
   output logic                     sda_oe
);
   import i2cm_pkg::*;

   i2cm_st_s st_r;
   i2cm_st_s st_nxt;

   always_comb begin
      logic       tick, srise, sfall, startd, stopd, busy, coll, push, hi, gc, rsv, m7;
      logic [7:0] pb, b;
      tick = 1'b0;
      coll = 1'b0;
      push = 1'b0;
      pb = 8'h00;
      st_nxt = st_r;
      st_nxt.scl_m = scl_i;
      st_nxt.scl_s = st_r.scl_m;
      st_nxt.scl_p = st_r.scl_s;
      st_nxt.sda_m = sda_i;
      st_nxt.sda_s = st_r.sda_m;
      st_nxt.sda_p = st_r.sda_s;
      srise = st_r.scl_s & ~st_r.scl_p;
      sfall = ~st_r.scl_s & st_r.scl_p;
      startd = st_r.scl_s & st_r.scl_p & st_r.sda_p & ~st_r.sda_s;
      stopd = st_r.scl_s & st_r.scl_p & ~st_r.sda_p & st_r.sda_s;
      busy = (st_r.ms != M_IDLE) | st_r.stat[S_TBF];
      b = st_r.ssh;
      rsv = (b[7:4] == 4'h0) | (b[7:3] == 5'h1F) | (b[7:3] == 5'h1E);
      gc = (b == 8'h00) & st_r.ctl[C_GC];
      m7 = ~rsv & ((((b[7:1] ^ st_r.own[6:0]) & ~st_r.msk[6:0]) == 7'h00)
           | st_r.ctl[C_ALL]);
      hi = (b[7:3] == 5'h1E) & ((((b[2:1] ^ st_r.own[9:8]) & ~st_r.msk[9:8]) == 2'h0)
           | st_r.ctl[C_ALL]);

      st_nxt.rdat = 16'h0000;
      if (bus.rd) begin
         case (bus.addr)
            REG_CTRL: st_nxt.rdat = st_r.ctl;
            REG_STAT: st_nxt.rdat = st_r.stat & STAT_IMPL;
            REG_MASK: st_nxt.rdat = st_r.msk & MASK_WMASK;
            REG_TX:   st_nxt.rdat = {8'h00, st_r.txh};
            REG_RX:   st_nxt.rdat = {8'h00, st_r.rxh};
            REG_ADDR: st_nxt.rdat = st_r.own;
            REG_BRG:  st_nxt.rdat = st_r.brg;
            default:  st_nxt.rdat = 16'h0000;
         endcase
         if (bus.addr == REG_RX) begin
            st_nxt.stat[S_RBF] = 1'b0;
         end
      end
      if (bus.wr) begin
         case (bus.addr)
            REG_CTRL: st_nxt.ctl = bus.wdata & CTRL_WMASK;
            REG_STAT: st_nxt.stat = st_r.stat & ~(STAT_CMASK & ~bus.wdata);
            REG_MASK: st_nxt.msk = bus.wdata & MASK_WMASK;
            REG_TX: begin
               if (busy) begin
                  st_nxt.stat[S_WCOL] = 1'b1;
               end else begin
                  st_nxt.txh = bus.wdata[7:0];
                  st_nxt.stat[S_TBF] = 1'b1;
               end
            end
            REG_ADDR: st_nxt.own = bus.wdata & ADDR_WMASK;
            REG_BRG: begin
               st_nxt.brg = bus.wdata;
               st_nxt.cnt = 16'h0000;
            end
            default: ;
         endcase
      end

      // A zero reload still gives one tick per cycle, so the bus never stalls.
      if (st_r.cnt == 16'h0000) begin
         tick = 1'b1;
         st_nxt.cnt = st_r.brg;
      end else begin
         st_nxt.cnt = st_r.cnt - 16'h0001;
      end

      if (startd) begin
         st_nxt.stat[S_S] = 1'b1;
         st_nxt.stat[S_P] = 1'b0;
      end
      if (stopd) begin
         st_nxt.stat[S_P] = 1'b1;
         st_nxt.stat[S_S] = 1'b0;
         st_nxt.stat[S_GC] = 1'b0;
         st_nxt.stat[S_A10] = 1'b0;
      end

      // Request bits stay set until the sequence ends so software can poll them.
      if (tick && !(st_r.ph == 2'd2 && !st_r.scl_s && st_r.ms >= M_TX)) begin
         st_nxt.ph = st_r.ph + 2'd1;
      end
      case (st_r.ms)
         M_IDLE: begin
            st_nxt.ph = 2'd0;
            st_nxt.bc = 4'h0;
            if (st_r.ctl[C_ST]) st_nxt.ms = M_START;
            else if (st_r.ctl[C_RS]) st_nxt.ms = M_RSTART;
            else if (st_r.ctl[C_STOP]) st_nxt.ms = M_STOP;
            else if (st_r.ctl[C_ACK]) st_nxt.ms = M_ACK;
            else if (st_r.ctl[C_RCV]) st_nxt.ms = M_RX;
            else if (st_r.stat[S_TBF] && st_r.mst) begin
               st_nxt.ms = M_TX;
               st_nxt.sh = st_r.txh;
               st_nxt.stat[S_TRS] = 1'b1;
            end
         end
         M_START: if (tick) begin
            case (st_r.ph)
               2'd0: coll = ~st_r.sda_s | ~st_r.scl_s;
               2'd1: st_nxt.sda_dm = 1'b1;
               2'd2: st_nxt.scl_dm = 1'b1;
               default: begin
                  st_nxt.ctl[C_ST] = 1'b0;
                  st_nxt.mst = 1'b1;
                  st_nxt.ms = M_IDLE;
               end
            endcase
         end
         M_RSTART: if (tick) begin
            case (st_r.ph)
               2'd0: st_nxt.sda_dm = 1'b0;
               2'd1: st_nxt.scl_dm = 1'b0;
               2'd2: begin
                  coll = ~st_r.sda_s;
                  st_nxt.sda_dm = 1'b1;
               end
               default: begin
                  st_nxt.scl_dm = 1'b1;
                  st_nxt.ctl[C_RS] = 1'b0;
                  st_nxt.ms = M_IDLE;
               end
            endcase
         end
         M_STOP: if (tick) begin
            case (st_r.ph)
               2'd0: st_nxt.sda_dm = 1'b1;
               2'd1: st_nxt.scl_dm = 1'b0;
               2'd2: st_nxt.sda_dm = 1'b0;
               default: begin
                  st_nxt.ctl[C_STOP] = 1'b0;
                  st_nxt.mst = 1'b0;
                  st_nxt.ms = M_IDLE;
               end
            endcase
         end
         M_TX, M_RX, M_ACK: if (tick) begin
            case (st_r.ph)
               2'd0: begin
                  st_nxt.scl_dm = 1'b1;
                  if (st_r.ms == M_ACK) st_nxt.sda_dm = ~st_r.ctl[C_ACKV];
                  else if (st_r.ms == M_TX && st_r.bc < 4'h8) st_nxt.sda_dm = ~st_r.sh[7];
                  else st_nxt.sda_dm = 1'b0;
               end
               2'd1: st_nxt.scl_dm = 1'b0;
               2'd2: if (st_r.scl_s) begin
                  st_nxt.sh = {st_r.sh[6:0], st_r.sda_s};
                  if (st_r.ms == M_TX && st_r.bc < 4'h8) coll = ~st_r.sda_dm & ~st_r.sda_s;
                  if (st_r.ms == M_TX && st_r.bc == 4'h8) st_nxt.stat[S_ACK] = st_r.sda_s;
               end
               default: begin
                  st_nxt.scl_dm = 1'b1;
                  st_nxt.bc = st_r.bc + 4'h1;
                  if (st_r.ms == M_TX && st_r.bc == 4'h8) begin
                     st_nxt.stat[S_TRS] = 1'b0;
                     st_nxt.stat[S_TBF] = 1'b0;
                     st_nxt.ms = M_IDLE;
                  end else if (st_r.ms == M_RX && st_r.bc == 4'h7) begin
                     st_nxt.ctl[C_RCV] = 1'b0;
                     push = 1'b1;
                     pb = st_nxt.sh;
                     st_nxt.ms = M_IDLE;
                  end else if (st_r.ms == M_ACK) begin
                     st_nxt.ctl[C_ACK] = 1'b0;
                     st_nxt.sda_dm = 1'b0;
                     st_nxt.ms = M_IDLE;
                  end
               end
            endcase
         end
         default: st_nxt.ms = M_IDLE;
      endcase
      if (coll) begin
         st_nxt.stat[S_BCL] = 1'b1;
         st_nxt.stat[S_TRS] = 1'b0;
         st_nxt.ctl[4:0] = 5'h00;
         st_nxt.sda_dm = 1'b0;
         st_nxt.scl_dm = 1'b0;
         st_nxt.mst = 1'b0;
         st_nxt.ms = M_IDLE;
      end

      // The slave side does not stretch the clock; software must keep up with the bus.
      if (st_r.mst || st_r.ms != M_IDLE) begin
         st_nxt.ss = S_IDLE;
         st_nxt.sda_ds = 1'b0;
      end else if (startd) begin
         st_nxt.ss = S_ADDR;
         st_nxt.sbc = 4'h0;
         st_nxt.sda_ds = 1'b0;
      end else if (stopd) begin
         st_nxt.ss = S_IDLE;
         st_nxt.lw = 1'b0;
         st_nxt.sda_ds = 1'b0;
      end else if (st_r.ss != S_IDLE && st_r.ss != S_IGN) begin
         if (srise && st_r.ss != S_TX && st_r.sbc < 4'h8) begin
            st_nxt.ssh = {st_r.ssh[6:0], st_r.sda_s};
            st_nxt.sbc = st_r.sbc + 4'h1;
         end
         if (srise && st_r.ss == S_TX && st_r.sbc < 4'h9) begin
            if (st_r.sbc == 4'h8) st_nxt.sgo = st_r.sda_s ? S_IGN : S_TX;
            st_nxt.sbc = st_r.sbc + 4'h1;
         end
         if (sfall && st_r.sbc == 4'h9) begin
            st_nxt.sbc = 4'h0;
            st_nxt.ss = st_r.sgo;
            st_nxt.sda_ds = 1'b0;
            if (st_r.ss == S_TX) begin
               st_nxt.stat[S_TBF] = 1'b0;
               st_nxt.stat[S_DA] = 1'b1;
            end
            if (st_r.sgo == S_TX) begin
               st_nxt.sda_ds = ~st_r.txh[7];
               st_nxt.ssh = {st_r.txh[6:0], 1'b0};
            end
         end else if (sfall && st_r.ss == S_TX) begin
            st_nxt.sda_ds = (st_r.sbc < 4'h8) ? ~st_r.ssh[7] : 1'b0;
            st_nxt.ssh = {st_r.ssh[6:0], 1'b0};
         end else if (sfall && st_r.sbc == 4'h8) begin
            st_nxt.sbc = 4'h9;
            st_nxt.sgo = S_IGN;
            if (st_r.ss == S_RX) begin
               push = 1'b1;
               pb = b;
               st_nxt.stat[S_DA] = 1'b1;
               st_nxt.sda_ds = 1'b1;
               st_nxt.sgo = S_RX;
            end else if (st_r.lw) begin
               st_nxt.lw = 1'b0;
               if (((b ^ st_r.own[7:0]) & ~st_r.msk[7:0]) == 8'h00 || st_r.ctl[C_ALL]) begin
                  st_nxt.stat[S_A10] = 1'b1;
                  st_nxt.stat[S_DA] = 1'b0;
                  st_nxt.stat[S_RW] = 1'b0;
                  st_nxt.sda_ds = 1'b1;
                  st_nxt.sgo = S_RX;
               end
            end else if (gc) begin
               st_nxt.stat[S_GC] = 1'b1;
               st_nxt.stat[S_DA] = 1'b0;
               st_nxt.stat[S_RW] = 1'b0;
               st_nxt.sda_ds = 1'b1;
               st_nxt.sgo = S_RX;
            end else if (st_r.ctl[C_A10] && hi && (!b[0] || st_r.stat[S_A10])) begin
               st_nxt.lw = ~b[0];
               st_nxt.stat[S_RW] = b[0];
               st_nxt.sda_ds = 1'b1;
               st_nxt.sgo = b[0] ? S_TX : S_ADDR;
            end else if (!st_r.ctl[C_A10] && m7) begin
               st_nxt.stat[S_DA] = 1'b0;
               st_nxt.stat[S_RW] = b[0];
               st_nxt.sda_ds = 1'b1;
               st_nxt.sgo = b[0] ? S_TX : S_RX;
            end
         end
      end

      if (push) begin
         if (st_nxt.stat[S_RBF]) begin
            st_nxt.stat[S_OV] = 1'b1;
         end else begin
            st_nxt.rxh = pb;
            st_nxt.stat[S_RBF] = 1'b1;
         end
      end
      if (!st_r.ctl[C_EN]) begin
         st_nxt.ms = M_IDLE;
         st_nxt.ss = S_IDLE;
         st_nxt.mst = 1'b0;
         st_nxt.sda_dm = 1'b0;
         st_nxt.scl_dm = 1'b0;
         st_nxt.sda_ds = 1'b0;
      end
      st_nxt.sda_oe = st_nxt.sda_dm | st_nxt.sda_ds;
      st_nxt.scl_oe = st_nxt.scl_dm;
   end

   // Synchronisers reset high so an idle bus shows no false Start after reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.scl_m <= 1'b1;
         st_r.scl_s <= 1'b1;
         st_r.scl_p <= 1'b1;
         st_r.sda_m <= 1'b1;
         st_r.sda_s <= 1'b1;
         st_r.sda_p <= 1'b1;
         st_r.own <= OWN_RST;
         st_r.brg <= BRG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data = st_r.rdat;
   assign scl_oe = st_r.scl_oe;
   assign sda_oe = st_r.sda_oe;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ack_drive_a: assert property (st_r.ms == M_ACK && st_r.ph == 2'd2 |-> sda_oe == !st_r.ctl[C_ACKV]) else $error("ack level wrong");
   ack_clear_a: assert property ($fell(st_r.ctl[C_ACK]) && !$past(bus.wr) |-> $past(st_r.ms) == M_ACK) else $error("ack request cleared early");
   rcv_clear_a: assert property ($fell(st_r.ctl[C_RCV]) && !$past(bus.wr) |-> $past(st_r.bc) == 4'h7) else $error("receive request cleared early");
   stop_clear_a: assert property ($fell(st_r.ctl[C_STOP]) && !$past(bus.wr) |-> !st_r.mst && $past(st_r.ms) == M_STOP) else $error("stop request misclear");
   start_clear_a: assert property ($fell(st_r.ctl[C_ST]) && !$past(bus.wr) && !st_r.stat[S_BCL] |-> st_r.mst) else $error("start ended without bus");
   ack_result_a: assert property (st_r.ms == M_TX && st_r.bc == 4'h8 && st_r.ph == 2'd2 && st_r.cnt == 16'h0000 && st_r.scl_s |=> st_r.stat[S_ACK] == $past(st_r.sda_s)) else $error("ack result not taken");
   tx_active_a: assert property ($rose(st_r.stat[S_TRS]) |-> st_r.ms == M_TX ##1 st_r.stat[S_TRS]) else $error("transmit flag wrong");
   bcl_hold_a: assert property (st_r.stat[S_BCL] && !(bus.wr && bus.addr == REG_STAT) |=> st_r.stat[S_BCL]) else $error("collision flag lost");
   stop_flags_a: assert property ($rose(st_r.stat[S_P]) |-> !st_r.stat[S_GC] && !st_r.stat[S_A10]) else $error("flags survive stop");
   wcol_set_a: assert property (bus.wr && bus.addr == REG_TX && st_r.ms != M_IDLE |=> st_r.stat[S_WCOL] && $stable(st_r.txh)) else $error("busy write not refused");
   stat_zero_a: assert property (bus.rd && bus.addr == REG_STAT |=> rd_data[13:11] == 3'b000 && rd_data[15:14] == $past(st_r.stat[15:14])) else $error("status read wrong");

   tx_byte_c: cover property ($fell(st_r.stat[S_TRS]));
   rx_byte_c: cover property ($fell(st_r.ctl[C_RCV]));
   ten_bit_c: cover property ($rose(st_r.stat[S_A10]));
   overflow_c: cover property ($rose(st_r.stat[S_OV]));
endmodule
`default_nettype wire

/* i2cm_peer.sv */
`timescale 1ns/100ps
`default_nettype none
// Behavioural bus slave. Lines are pulled up, so a released line reads as one.
// It acks its own address, sends a fixed byte on reads and stops sending on a NACK.
module i2cm_peer #(
   parameter logic [6:0] ADDR7 = 7'h2A,
   parameter logic [7:0] RDATA = 8'hC3
) (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic hold_low,
   output logic      sda_oe,
   output logic      last_ack
);
   logic [7:0] sh = 8'h00;
   logic       oe_r = 1'b0;
   logic       act = 1'b0;
   logic       sel = 1'b0;
   logic       rd = 1'b0;
   logic       first = 1'b0;
   int         bitn = 0;
   initial last_ack = 1'b0;
   // A held line lets the bench force a collision on the master.
   assign sda_oe = oe_r | hold_low;
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b1;
         first = 1'b1;
         sel = 1'b0;
         bitn = 0;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b0;
         oe_r = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (act) begin
         if (bitn < 8) begin
            sh = {sh[6:0], sda};
         end else if (sel && rd) begin
            last_ack = sda;
            // A NACK frees the data line so the master can signal Stop.
            sel = ~sda;
         end
         bitn++;
      end
   end
   always @(negedge scl) begin
      if (act) begin
         if (bitn == 8) begin
            if (first) begin
               sel = (sh[7:1] == ADDR7);
               rd = sh[0];
               first = 1'b0;
               oe_r = sel;
            end else begin
               oe_r = sel && !rd;
            end
         end else if (bitn == 9) begin
            bitn = 0;
            oe_r = sel && rd && !RDATA[7];
         end else if (bitn > 0 && sel && rd) begin
            oe_r = !RDATA[7 - bitn];
         end
      end
   end
endmodule
`default_nettype wire

/* i2cm_pkg.sv */
`default_nettype none
package i2cm_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned SCL_HZ = 100_000;
   localparam logic [2:0]  REG_CTRL = 3'h0;
   localparam logic [2:0]  REG_STAT = 3'h1;
   localparam logic [2:0]  REG_MASK = 3'h2;
   localparam logic [2:0]  REG_TX   = 3'h3;
   localparam logic [2:0]  REG_RX   = 3'h4;
   localparam logic [2:0]  REG_ADDR = 3'h5;
   localparam logic [2:0]  REG_BRG  = 3'h6;
   localparam int C_EN   = 15;
   localparam int C_ALL  = 11;
   localparam int C_A10  = 10;
   localparam int C_GC   = 7;
   localparam int C_ACKV = 5;
   localparam int C_ACK  = 4;
   localparam int C_RCV  = 3;
   localparam int C_STOP = 2;
   localparam int C_RS   = 1;
   localparam int C_ST   = 0;
   localparam int S_ACK  = 15;
   localparam int S_TRS  = 14;
   localparam int S_BCL  = 10;
   localparam int S_GC   = 9;
   localparam int S_A10  = 8;
   localparam int S_WCOL = 7;
   localparam int S_OV   = 6;
   localparam int S_DA   = 5;
   localparam int S_P    = 4;
   localparam int S_S    = 3;
   localparam int S_RW   = 2;
   localparam int S_RBF  = 1;
   localparam int S_TBF  = 0;
   localparam logic [15:0] CTRL_WMASK = 16'h8CBF;
   localparam logic [15:0] STAT_CMASK = 16'h04C0;
   localparam logic [15:0] STAT_IMPL  = 16'hC7FF;
   localparam logic [15:0] MASK_WMASK = 16'h03FF;
   localparam logic [15:0] ADDR_WMASK = 16'h03FF;
   localparam logic [15:0] OWN_RST    = 16'h0050;
   localparam logic [15:0] BRG_RST    = 16'(CLK_HZ / (4 * SCL_HZ) - 1);
   typedef enum logic [2:0] {M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK} i2cm_mst_e;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_IGN} i2cm_slv_e;
   typedef struct packed {
      logic [2:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } i2cm_bus_s;
   typedef struct packed {
      logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
      logic [15:0] ctl, stat, msk, own, brg, cnt, rdat;
      logic [7:0]  txh, rxh, sh, ssh;
      i2cm_mst_e   ms;
      i2cm_slv_e   ss, sgo;
      logic [1:0]  ph;
      logic [3:0]  bc, sbc;
      logic mst, lw, sda_dm, scl_dm, sda_ds, sda_oe, scl_oe;
   } i2cm_st_s;
endpackage
`default_nettype wire

/* tb_i2cm_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_i2cm_ctrl;
   import i2cm_pkg::*;
   localparam logic [6:0] PEER = 7'h2A;
   localparam logic [7:0] PDAT = 8'hC3;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   i2cm_bus_s   bus = '0;
   logic [15:0] rd_data;
   logic        scl_oe;
   logic        sda_oe;
   logic        peer_oe;
   logic        hold_low = 1'b0;
   logic        last_ack;
   logic        bb_scl = 1'b0;
   logic        bb_sda = 1'b0;
   logic        ack_b;
   logic [15:0] v;
   int          errors = 0;
   int          n_tests = 0;
   int          cyc = 0;
   wire         scl_w = ~(scl_oe | bb_scl);
   wire         sda_w = ~(sda_oe | peer_oe | bb_sda);
   always #10 clk = ~clk;
   i2cm_ctrl i2cm_ctrl_inst (
      .clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data),
      .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe)
   );
   i2cm_peer #(.ADDR7(PEER), .RDATA(PDAT)) i2cm_peer_inst (
      .scl(scl_w), .sda(sda_w), .hold_low(hold_low), .sda_oe(peer_oe), .last_ack(last_ack)
   );
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rd_data;
   endtask
   // Polls until the masked bits fall, bounded so a stuck bit shows as a mismatch.
   task automatic wait_clr(input string name, input logic [2:0] a, input logic [15:0] m);
      int k;
      k = 0;
      rd(a, v);
      while ((v & m) !== 16'h0000 && k < 500) begin
         rd(a, v);
         k++;
      end
      chk(name, v & m, 16'h0000);
   endtask
   // One request at a time, each awaited before the next is written.
   task automatic seq(input string name, input logic [15:0] c);
      wr(REG_CTRL, 16'h8000 | c);
      rd(REG_CTRL, v);
      chk({name, "_busy"}, v & c & 16'h001F, c & 16'h001F);
      wait_clr(name, REG_CTRL, c & 16'h001F);
   endtask
   // The bench acts as a second bus master with 80 ns steps to reach the slave side.
   // The clock line only moves in its own step, so the peer never sees a false Start.
   task automatic bb_step(input logic scl_low, input logic sda_low);
      bb_scl <= scl_low;
      bb_sda <= sda_low;
      repeat (4) @(posedge clk);
   endtask
   task automatic bb_start();
      bb_step(bb_scl, 1'b0);
      bb_step(1'b0, 1'b0);
      bb_step(1'b0, 1'b1);
      bb_step(1'b1, 1'b1);
   endtask
   task automatic bb_stop();
      bb_step(1'b1, 1'b1);
      bb_step(1'b0, 1'b1);
      bb_step(1'b0, 1'b0);
   endtask
   task automatic bb_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bb_step(1'b1, bb_sda);
         bb_step(1'b1, ~d[i]);
         bb_step(1'b0, ~d[i]);
      end
      bb_step(1'b1, bb_sda);
      bb_step(1'b1, 1'b0);
      bb_step(1'b0, 1'b0);
      ack = sda_w;
      bb_step(1'b1, 1'b0);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(REG_STAT, v);
      chk("stat_reset", v, 16'h0000);
      rd(REG_MASK, v);
      chk("mask_reset", v, 16'h0000);
      wr(REG_MASK, 16'hFFFF);
      rd(REG_MASK, v);
      chk("mask_bits", v, 16'h03FF);
      wr(REG_MASK, 16'h0000);
      rd(3'h7, v);
      chk("unmapped", v, 16'h0000);
      wr(REG_BRG, 16'h0001);
      $display("test registers done");
      seq("start", 16'h0001);
      rd(REG_STAT, v);
      chk("start_seen", v & 16'h0018, 16'h0008);
      wr(REG_TX, {8'h00, PEER, 1'b0});
      wr(REG_TX, 16'h00FF);
      rd(REG_STAT, v);
      chk("tx_busy", v & 16'h4081, 16'h4081);
      wait_clr("tx_done", REG_STAT, 16'h4001);
      chk("ack_addr", v & 16'h8080, 16'h0080);
      wr(REG_STAT, 16'h0000);
      rd(REG_STAT, v);
      chk("wcol_clear", v[S_WCOL], 1'b0);
      $display("test address write done");
      seq("restart", 16'h0002);
      wr(REG_TX, {8'h00, PEER, 1'b1});
      wait_clr("tx_read", REG_STAT, 16'h4001);
      seq("recv1", 16'h0008);
      rd(REG_STAT, v);
      chk("rx_full", v & 16'h0042, 16'h0002);
      seq("ack0", 16'h0010);
      chk("ack_sent0", last_ack, 1'b0);
      seq("recv2", 16'h0008);
      rd(REG_STAT, v);
      chk("overflow", v & 16'h0042, 16'h0042);
      rd(REG_RX, v);
      chk("rx_byte", v & 16'h00FF, {8'h00, PDAT});
      rd(REG_STAT, v);
      chk("rx_read", v & 16'h0002, 16'h0000);
      seq("ack1", 16'h0030);
      chk("ack_sent1", last_ack, 1'b1);
      seq("stop", 16'h0004);
      rd(REG_STAT, v);
      chk("stop_seen", v & 16'h0018, 16'h0010);
      wr(REG_STAT, 16'h0000);
      rd(REG_STAT, v);
      chk("ovf_clear", v[S_OV], 1'b0);
      $display("test master read done");
      seq("start2", 16'h0001);
      wr(REG_TX, {8'h00, 7'h31, 1'b0});
      wait_clr("tx_nack", REG_STAT, 16'h4001);
      chk("nack_seen", v[S_ACK], 1'b1);
      seq("stop2", 16'h0004);
      $display("test address nack done");
      hold_low <= 1'b1;
      wr(REG_CTRL, 16'h8001);
      wait_clr("abort", REG_CTRL, 16'h0001);
      hold_low <= 1'b0;
      rd(REG_STAT, v);
      chk("collision", v[S_BCL], 1'b1);
      wr(REG_STAT, 16'h0000);
      rd(REG_STAT, v);
      chk("coll_clear", v[S_BCL], 1'b0);
      $display("test collision done");
      bb_start();
      bb_byte(8'hA0, ack_b);
      chk("slv_addr_ack", ack_b, 1'b0);
      rd(REG_STAT, v);
      chk("slv_addr_stat", v & 16'h002C, 16'h0008);
      bb_byte(8'h5A, ack_b);
      chk("slv_data_ack", ack_b, 1'b0);
      rd(REG_STAT, v);
      chk("slv_data_stat", v & 16'h0022, 16'h0022);
      rd(REG_RX, v);
      chk("slv_rx_byte", v, 16'h005A);
      bb_stop();
      rd(REG_STAT, v);
      chk("slv_stop", v & 16'h0218, 16'h0010);
      bb_start();
      bb_byte(8'h00, ack_b);
      chk("gc_disabled", ack_b, 1'b1);
      wr(REG_CTRL, 16'h8080);
      bb_start();
      bb_byte(8'h00, ack_b);
      chk("gc_ack", ack_b, 1'b0);
      rd(REG_STAT, v);
      chk("gc_seen", v[S_GC], 1'b1);
      bb_stop();
      rd(REG_STAT, v);
      chk("gc_stop", v[S_GC], 1'b0);
      wr(REG_MASK, 16'h03FF);
      bb_start();
      bb_byte(8'h08, ack_b);
      chk("reserved_nack", ack_b, 1'b1);
      bb_start();
      bb_byte(8'h7E, ack_b);
      chk("masked_ack", ack_b, 1'b0);
      bb_stop();
      $display("test slave done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
